// ==== inc/pcdim_params.svh ====
`ifndef PCDIM_PARAMS_SVH
`define PCDIM_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define PCD_CLK_MHZ        250

// ----------------------------------------
// Dimming pulse timing
// ----------------------------------------
`define PCD_PLT_MIN_NS     200
`define PCD_PLT_CYC        ((`PCD_PLT_MIN_NS * `PCD_CLK_MHZ + 999) / 1000)
`define PCD_PHT_MIN_NS     200
`define PCD_PHT_CYC        ((`PCD_PHT_MIN_NS * `PCD_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Low time to shutdown
// ----------------------------------------
`define PCD_SHDN_MS        30
`define PCD_SHDN_CYC       (`PCD_SHDN_MS * `PCD_CLK_MHZ * 1000)
`define PCD_TMR_W          23

// ----------------------------------------
// Gain stage evaluation
// ----------------------------------------
`define PCD_EVAL_NS        1000
`define PCD_EVAL_CYC       ((`PCD_EVAL_NS * `PCD_CLK_MHZ) / 1000)
`define PCD_EVAL_W         8
`define PCD_HYS_MV         300

// ----------------------------------------
// Levels and widths
// ----------------------------------------
`define PCD_LVL_W          5
`define PCD_CODE_W         6
`define PCD_FULL_CODE      6'h20
`define PCD_LVL_ZERO       5'h0
`define PCD_LVL_ONE        5'h1
`define PCD_NCHAN          6
`define PCD_SENSE_W        5

`endif

// ==== inc/pcdim_pkg.sv ====
`include "pcdim_params.svh"

package pcdim_pkg;

  // Asynchronous sense inputs, analog comparators and host pins
  typedef struct packed {
    logic uvlo;        // Supply below lockout level
    logic reg_lost;    // Some channel out of regulation
    logic sup_ok_1x;   // Supply enough for 1x, hysteresis included
    logic duty;        // Duty-cycle gating input
    logic dim;         // Pulse dimming input
  } pcdim_sense_t;

  // Drive to the analog channel stage
  typedef struct packed {
    logic                   hiz;
    logic [`PCD_NCHAN-1:0]  en;
    logic [`PCD_CODE_W-1:0] code;
  } pcdim_chan_t;

  typedef enum logic [1:0] {
    PCD_ST_SHDN = 2'b01,
    PCD_ST_RUN  = 2'b10
  } pcdim_state_t;

  typedef enum logic [3:0] {
    PCD_G_1X00 = 4'b0001,
    PCD_G_1X33 = 4'b0010,
    PCD_G_1X50 = 4'b0100,
    PCD_G_2X00 = 4'b1000
  } pcdim_gain_t;

endpackage : pcdim_pkg

// ==== hw/pcdim_sync.sv ====
`timescale 1ns/1ns
`include "pcdim_params.svh"

module pcdim_sync
  import pcdim_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire pcdim_sense_t async_in,
  output pcdim_sense_t      sync_out
);

  pcdim_sense_t meta_ff;
  pcdim_sense_t sync_ff;

  // First stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : pcdim_sync

// ==== hw/pcdim_lowtimer.sv ====
`timescale 1ns/1ns
`include "pcdim_params.svh"

module pcdim_lowtimer #(
  parameter int unsigned LIMIT = 1
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic clr,
  input  wire logic level_in,
  output logic      expired
);

  logic [`PCD_TMR_W-1:0] cnt_ff;
  logic                  exp_ff;

  // Any high level restarts the count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (clr || level_in || exp_ff) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + `PCD_TMR_W'(1);
    end
  end

  // Sticky until the level rises again or clr is raised
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exp_ff <= 1'b0;
    end else if (clr || level_in) begin
      exp_ff <= 1'b0;
    end else if (cnt_ff == `PCD_TMR_W'(LIMIT - 1)) begin
      exp_ff <= 1'b1;
    end
  end

  assign expired = exp_ff;

endmodule : pcdim_lowtimer

// ==== hw/pcdim_top.sv ====
// Behaviour
// - Power-up selects 1x gain and stays there while channels regulate.
// - Loss of regulation steps gain one stage up: 1x, 1.33x, 1.5x, 2x.
// - Sufficient supply returns gain directly to 1x, never to a middle stage.
// - Leave and return levels for 1x differ by about 300 mV hysteresis.
// - Under-voltage lockout disables all channels and enters shutdown.
// - First dimming rising edge after reset or shutdown enables at full scale.
// - Each later rising edge lowers the shared level by one thirty-second.
// - After 31 pulses the next rising edge wraps back to full scale.
// - Rising edges after a too-short low phase are ignored, except the edge that wakes from shutdown.
// - Dimming input low longer than 30 ms enters shutdown.
// - Duty input high passes the level to all six channels, low forces zero.
// - Duty input low longer than 30 ms also enters shutdown.
// - In shutdown all channel outputs are high impedance with zero current.
// - One level shared by all channels; dimming input enables and sets it.
`timescale 1ns/1ns
`include "pcdim_params.svh"

module pcdim_top
  import pcdim_pkg::*;
#(
  parameter int unsigned SHDN_CYC = `PCD_SHDN_CYC
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire pcdim_sense_t sense_in,
  output pcdim_chan_t       chan_out,
  output pcdim_gain_t       gain_mode,
  output logic [`PCD_LVL_W-1:0] pulse_count,
  output logic              shutdown
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Current code is 32 - n in units of full scale / 32
  function automatic logic [`PCD_CODE_W-1:0] level_to_code(input logic [`PCD_LVL_W-1:0] lvl);
    level_to_code = `PCD_FULL_CODE - {1'b0, lvl};
  endfunction : level_to_code

  // Wrap written out so the lowest level is a visible end point
  function automatic logic [`PCD_LVL_W-1:0] level_next(input logic [`PCD_LVL_W-1:0] lvl);
    if (&lvl) begin
      level_next = `PCD_LVL_ZERO;
    end else begin
      level_next = lvl + `PCD_LVL_ONE;
    end
  endfunction : level_next

  function automatic logic state_is_shdn(input pcdim_state_t s);
    state_is_shdn = (s == PCD_ST_SHDN);
  endfunction : state_is_shdn

  function automatic pcdim_gain_t gain_step_up(input pcdim_gain_t g);
    unique case (g)
      PCD_G_1X00: gain_step_up = PCD_G_1X33;
      PCD_G_1X33: gain_step_up = PCD_G_1X50;
      PCD_G_1X50: gain_step_up = PCD_G_2X00;
      PCD_G_2X00: gain_step_up = PCD_G_2X00;
      default:    gain_step_up = PCD_G_1X00;
    endcase
  endfunction : gain_step_up

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  pcdim_sense_t sense_s;

  pcdim_sync u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (sense_in),
    .sync_out (sense_s)
  );

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  pcdim_state_t          state_ff;
  pcdim_state_t          nxt_state;
  pcdim_gain_t           gain_ff;
  pcdim_gain_t           nxt_gain;
  logic                  dim_q_ff;
  logic                  dim_rise;
  logic                  high_ok_ff;
  logic [`PCD_TMR_W-1:0] high_cnt_ff;
  logic                  low_ok;
  logic                  dim_dead;
  logic                  duty_dead;
  logic                  in_shdn;
  logic                  wake;
  logic                  go_shdn;
  logic                  step_ok;
  logic [`PCD_LVL_W-1:0] level_ff;
  logic [`PCD_EVAL_W-1:0] eval_cnt_ff;
  logic                  eval_tick;
  pcdim_chan_t           chan_ff;
  logic                  shdn_ff;
  logic                  shdn_next;
  pcdim_chan_t           nxt_chan;

  assign in_shdn = state_is_shdn(state_ff);

  // ----------------------------------------
  // Low-time timers
  // ----------------------------------------
  // Short timer qualifies dimming edges
  pcdim_lowtimer #(
    .LIMIT (`PCD_PLT_CYC)
  ) u_plt (
    .mclk     (mclk),
    .nrst     (nrst),
    .clr      (1'b0),
    .level_in (sense_s.dim),
    .expired  (low_ok)
  );

  // Held cleared in shutdown so wake-up starts a fresh count
  pcdim_lowtimer #(
    .LIMIT (SHDN_CYC)
  ) u_dim_to (
    .mclk     (mclk),
    .nrst     (nrst),
    .clr      (in_shdn),
    .level_in (sense_s.dim),
    .expired  (dim_dead)
  );

  pcdim_lowtimer #(
    .LIMIT (SHDN_CYC)
  ) u_duty_to (
    .mclk     (mclk),
    .nrst     (nrst),
    .clr      (in_shdn),
    .level_in (sense_s.duty),
    .expired  (duty_dead)
  );

  // ----------------------------------------
  // Dimming edge detection
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dim_q_ff <= 1'b0;
    end else begin
      dim_q_ff <= sense_s.dim;
    end
  end

  assign dim_rise = sense_s.dim & ~dim_q_ff;

  // High phase length; a runt high is not counted on its own but
  // its edge was already qualified by the preceding low, so this
  // only gates the next edge after a glitch-like high
  // The rise cycle itself counts, so a high of exactly the minimum passes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      high_cnt_ff <= '0;
    end else if (!sense_s.dim) begin
      high_cnt_ff <= '0;
    end else if (!high_ok_ff || dim_rise) begin
      high_cnt_ff <= high_cnt_ff + `PCD_TMR_W'(1);
    end
  end

  // Cleared at a new edge, set once the high lasted long enough
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      high_ok_ff <= 1'b1;
    end else if (dim_rise) begin
      high_ok_ff <= 1'b0;
    end else if (sense_s.dim && high_cnt_ff == `PCD_TMR_W'(`PCD_PHT_CYC - 1)) begin
      high_ok_ff <= 1'b1;
    end
  end

  // Edge counts only after full low and high phases
  assign step_ok = dim_rise & low_ok & high_ok_ff;

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  assign wake    = in_shdn & dim_rise & ~sense_s.uvlo;
  assign go_shdn = sense_s.uvlo | dim_dead | duty_dead;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PCD_ST_SHDN: begin
        if (wake) begin
          nxt_state = PCD_ST_RUN;
        end
      end
      PCD_ST_RUN: begin
        if (go_shdn) begin
          nxt_state = PCD_ST_SHDN;
        end
      end
      default: begin
        nxt_state = PCD_ST_SHDN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= PCD_ST_SHDN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Pulse count
  // ----------------------------------------
  // Counts only while running; shutdown restarts at full scale
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= `PCD_LVL_ZERO;
    end else if (in_shdn) begin
      level_ff <= `PCD_LVL_ZERO;
    end else if (!go_shdn && step_ok) begin
      level_ff <= level_next(level_ff);
    end
  end

  // ----------------------------------------
  // Gain stage selection
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eval_cnt_ff <= '0;
    end else if (in_shdn || eval_tick) begin
      eval_cnt_ff <= '0;
    end else begin
      eval_cnt_ff <= eval_cnt_ff + `PCD_EVAL_W'(1);
    end
  end

  assign eval_tick = (eval_cnt_ff == `PCD_EVAL_W'(`PCD_EVAL_CYC - 1));

  // Hysteresis lives in the two comparator levels; the logic only
  // trusts sup_ok_1x for the way down, so a marginal supply
  // cannot make it toggle
  always_comb begin
    nxt_gain = gain_ff;
    if (in_shdn) begin
      nxt_gain = PCD_G_1X00;
    end else if (eval_tick) begin
      if (sense_s.sup_ok_1x) begin
        nxt_gain = PCD_G_1X00;
      end else if (sense_s.reg_lost) begin
        nxt_gain = gain_step_up(gain_ff);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_ff <= PCD_G_1X00;
    end else begin
      gain_ff <= nxt_gain;
    end
  end

  // ----------------------------------------
  // Channel drive
  // ----------------------------------------
  // Driven from the next state so the pins move with the state register
  assign shdn_next = state_is_shdn(nxt_state);

  always_comb begin
    nxt_chan.hiz  = shdn_next;
    nxt_chan.en   = {`PCD_NCHAN{(nxt_state == PCD_ST_RUN) & sense_s.duty}};
    nxt_chan.code = level_to_code(level_ff);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chan_ff.hiz  <= 1'b1;
      chan_ff.en   <= '0;
      chan_ff.code <= `PCD_FULL_CODE;
    end else begin
      chan_ff <= nxt_chan;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shdn_ff <= 1'b1;
    end else begin
      shdn_ff <= shdn_next;
    end
  end

  assign chan_out    = chan_ff;
  assign gain_mode   = gain_ff;
  assign pulse_count = level_ff;
  assign shutdown    = shdn_ff;

endmodule : pcdim_top

// ==== verif/pcdim_top_asserts.sv ====
`timescale 1ns/1ns
`include "pcdim_params.svh"

module pcdim_top_asserts
  import pcdim_pkg::*;
#(
  parameter int unsigned SHDN_CYC = 1
) (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire pcdim_sense_t          sense_in,
  input wire pcdim_chan_t           chan_out,
  input wire pcdim_gain_t           gain_mode,
  input wire logic [`PCD_LVL_W-1:0] pulse_count,
  input wire logic                  shutdown
);
  // ------------------------------
  // Dim low-time watch
  // ------------------------------
  logic [31:0] lo_cnt_ff;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lo_cnt_ff <= 32'h0000_0000;
    end else if (sense_in.dim || shutdown) begin
      lo_cnt_ff <= 32'h0000_0000;
    end else begin
      lo_cnt_ff <= lo_cnt_ff + 32'h0000_0001;
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  gain_step_a:
  assert property (gain_mode != $past(gain_mode) |->
    gain_mode == PCD_G_1X00 || gain_mode == ($past(gain_mode) << 1))
    else $error("gain skipped a stage");
  gain_hold_a:
  assert property (gain_mode != $past(gain_mode) |=> $stable(gain_mode) [*8])
    else $error("gain changed twice in an interval");
  shdn_gain_a:
  assert property (shutdown |=> gain_mode == PCD_G_1X00)
    else $error("gain not 1x in shutdown");
  shdn_hiz_a:
  assert property (shutdown |-> ##[0:1] (chan_out.hiz && chan_out.en == 6'h00))
    else $error("outputs live in shutdown");
  uvlo_shdn_a:
  assert property (sense_in.uvlo [*2] |-> ##[0:2] shutdown)
    else $error("lockout did not shut down");
  dim_wake_a:
  assert property (shutdown && $past(shutdown) && $rose(sense_in.dim) && !sense_in.uvlo
    |-> ##[2:4] (!shutdown && pulse_count == 5'h00))
    else $error("no wake at full scale");
  count_step_a:
  assert property ($changed(pulse_count) && !shutdown && !$past(shutdown)
    |-> pulse_count == $past(pulse_count) + 5'h01)
    else $error("count step wrong");
  code_map_a:
  assert property (!shutdown |=> chan_out.code == 6'h20 - {1'b0, $past(pulse_count)})
    else $error("code does not match count");
  duty_gate_a:
  assert property (!shutdown [*4] |-> chan_out.en == {6{$past(sense_in.duty, 3)}})
    else $error("enables do not follow duty");
  dim_timeout_a:
  assert property (lo_cnt_ff <= SHDN_CYC + 32'h0000_0006)
    else $error("no shutdown after long dim low");
endmodule : pcdim_top_asserts

bind pcdim_top pcdim_top_asserts #(.SHDN_CYC(SHDN_CYC)) u_chk (
  .mclk        (mclk),
  .nrst        (nrst),
  .sense_in    (sense_in),
  .chan_out    (chan_out),
  .gain_mode   (gain_mode),
  .pulse_count (pulse_count),
  .shutdown    (shutdown)
);

// ==== verif/pcdim_host_model.sv ====
`timescale 1ns/1ns

module pcdim_host_model (
  input  wire logic mclk,
  output logic      dim,
  output logic      duty
);
  // ------------------------------
  // Host pins, dim idles low
  // ------------------------------
  initial begin
    dim  = 1'b0;
    duty = 1'b1;
  end

  task automatic pulse(input int lo, input int hi);
    @(posedge mclk) dim <= 1'b0;
    repeat (lo) @(posedge mclk);
    dim <= 1'b1;
    repeat (hi) @(posedge mclk);
  endtask : pulse
endmodule : pcdim_host_model

// ==== verif/test_pulse_count_led_dimmer.sv ====
`timescale 1ns/1ns
`include "pcdim_params.svh"

module test_pulse_count_led_dimmer;
  import pcdim_pkg::*;
  localparam int unsigned SHDN = 2000;
  logic                  mclk, nrst, uvlo, reg_lost, sup_ok, dim, duty, shutdown;
  pcdim_chan_t           chan_out;
  pcdim_gain_t           gain_mode;
  logic [`PCD_LVL_W-1:0] pulse_count;
  int                    error_cnt, check_count, cyc, seed, n;

  pcdim_host_model host (.mclk(mclk), .dim(dim), .duty(duty));
  pcdim_top #(.SHDN_CYC(SHDN)) dut (
    .mclk        (mclk),
    .nrst        (nrst),
    .sense_in    ({uvlo, reg_lost, sup_ok, duty, dim}),
    .chan_out    (chan_out),
    .gain_mode   (gain_mode),
    .pulse_count (pulse_count),
    .shutdown    (shutdown)
  );

  // ------------------------------
  // Expectations and checks
  // ------------------------------
  function automatic pcdim_chan_t f_chan(input logic run, input int n);
    return {~run, {6{run}}, 6'(32 - n)};
  endfunction : f_chan
  function automatic pcdim_gain_t f_gain(input int k);
    return pcdim_gain_t'(4'(1 << k));
  endfunction : f_gain

  task automatic chk_chan(input pcdim_chan_t got, input pcdim_chan_t exp);
    @(negedge mclk);
    check_count++;
    if (chan_out !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, chan_out, exp);
    end
  endtask : chk_chan
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic wait_gain(input pcdim_gain_t g);
    for (int i = 0; i < 300 && gain_mode === g; i++) @(negedge mclk);
  endtask : wait_gain
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // ------------------------------
  // Clock and hang guard
  // ------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    seed = 32'h4255_caae;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    {nrst, uvlo, reg_lost, sup_ok} = 4'h0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    chk_chan(chan_out, f_chan(0, 0));
    chk_val(gain_mode, f_gain(0));
    host.pulse(60, 60);
    chk_chan(chan_out, f_chan(1, 0));
    // Lows add up past the timeout, so each high must restart it
    for (n = 1; n <= 33; n++) begin
      host.pulse(50 + {$random(seed)} % 40, 50 + {$random(seed)} % 40);
      chk_val(pulse_count, 8'(n % 32));
      chk_chan(chan_out, f_chan(1, n % 32));
    end
    host.pulse(10, 60);
    host.pulse(60, 10);
    host.pulse(60, 60);
    chk_val(pulse_count, 8'h02);
    for (n = 0; n < 8; n++) begin
      @(posedge mclk) host.duty <= ~n[0];
      repeat (625 + {$random(seed)} % 200) @(posedge mclk);
      chk_val(chan_out.en, {2'b00, {6{~n[0]}}});
    end
    @(posedge mclk) host.duty <= 1'b1;
    reg_lost <= 1'b1;
    for (n = 1; n < 5; n++) begin
      wait_gain(gain_mode);
      chk_val(gain_mode, f_gain(n > 3 ? 3 : n));
    end
    @(posedge mclk) sup_ok <= 1'b1;
    wait_gain(gain_mode);
    chk_val(gain_mode, f_gain(0));
    @(posedge mclk) {sup_ok, reg_lost} <= 2'b00;
    host.dim <= 1'b0;
    repeat (SHDN - 20) @(posedge mclk);
    chk_val(shutdown, 8'h00);
    repeat (30) @(posedge mclk);
    chk_chan(chan_out, f_chan(0, 0));
    host.pulse(60, 60);
    chk_chan(chan_out, f_chan(1, 0));
    @(posedge mclk) host.duty <= 1'b0;
    repeat (SHDN + 10) @(posedge mclk);
    chk_val(shutdown, 8'h01);
    @(posedge mclk) host.duty <= 1'b1;
    host.pulse(60, 60);
    @(posedge mclk) uvlo <= 1'b1;
    repeat (8) @(posedge mclk);
    chk_chan(chan_out, f_chan(0, 0));
    host.pulse(60, 60);
    chk_val(shutdown, 8'h01);
    @(posedge mclk) uvlo <= 1'b0;
    host.pulse(60, 60);
    chk_val(shutdown, 8'h00);
    host.pulse(60, 60);
    chk_val(pulse_count, 8'h01);
    // Mid-run reset with the dimming pin at its idle low level
    @(posedge mclk) host.dim <= 1'b0;
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    chk_chan(chan_out, f_chan(0, 0));
    chk_val(pulse_count, 8'h00);
    chk_val(gain_mode, f_gain(0));
    complete_run();
  end
endmodule : test_pulse_count_led_dimmer
